// ### shared/dci_pkg.sv
// Constants, field layouts and carrier types of the DDR init sequencer.
// Assumes a 200 MHz aclk and a device config port on its own link clock.
// How it works
// - Software probes bank sizes; sequencer turns them into chip-select bounds
// - All configuration words are loaded before memory is enabled
// - Per chip-select auto-precharge enable closes pages after each access
// - Write termination setting defaults to 001, other values allowed
// - Read termination forced off when only one chip select fitted
// - DDR3 termination power-down exit field is written as 0001
// - DDR3 with burst chop adds 2 to write recovery and write-to-read
// - Additive latency must be below activate-to-rw, else sequence aborts
// - DDR2 write latency is column latency minus one
// - DDR3 write latency is the programmed value
// - Enable only after configuration and clock settle time elapses
package dci_pkg;
	// Own register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_SIZE   = 8'h08;
	localparam logic [7:0] REG_TIM_A  = 8'h0c;
	localparam logic [7:0] REG_TIM_B  = 8'h10;
	localparam logic [7:0] REG_GEOM   = 8'h14;
	localparam logic [31:0] CTRL_RST  = 32'h0000_0100;
	// Device config word indices
	localparam logic [7:0] DEV_BOUNDS = 8'h00;
	localparam logic [7:0] DEV_SETUP  = 8'h04;
	localparam logic [7:0] DEV_TIM3   = 8'h08;
	localparam logic [7:0] DEV_TIM0   = 8'h09;
	localparam logic [7:0] DEV_TIM1   = 8'h0a;
	localparam logic [7:0] DEV_TIM2   = 8'h0b;
	localparam logic [7:0] DEV_CLKADJ = 8'h0c;
	localparam logic [7:0] DEV_MEMCFG = 8'h0d;
	// Sequence steps
	localparam logic [3:0] STEP_CLK   = 4'hc;
	localparam logic [3:0] STEP_EN    = 4'hd;
	// Device field positions
	localparam int P_BND_START = 16;
	localparam int P_SU_AP     = 31;
	localparam int P_SU_EN     = 30;
	localparam int P_SU_RDT    = 20;
	localparam int P_SU_WRT    = 16;
	localparam int P_SU_BA     = 14;
	localparam int P_SU_ROW    = 8;
	localparam int P_SU_COL    = 0;
	localparam int P_HI        = 4;
	localparam int P_T_B       = 8;
	localparam int P_T_C       = 16;
	localparam int P_T_D       = 24;
	localparam int P_CFG_EN    = 31;
	localparam int P_CFG_DDR3  = 24;
	localparam int P_CFG_BI    = 0;
	localparam logic [3:0] PD_EXIT_DDR3 = 4'h1;
	localparam logic [3:0] BC_EXTRA     = 4'h2;
	localparam logic [4:0] WL_OFFSET    = 5'h01;
	// Clock settle times
	localparam int CLK_MHZ         = 200;
	localparam int SETTLE_DDR2_US  = 200;
	localparam int SETTLE_DDR3_US  = 500;
	localparam int SETTLE_DDR2_CYC = SETTLE_DDR2_US * CLK_MHZ;
	localparam int SETTLE_DDR3_CYC = SETTLE_DDR3_US * CLK_MHZ;
	localparam int CNT_W           = 17;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] data;
	} dci_cfg_t;
	typedef enum logic [5:0] {
		ST_IDLE   = 6'b000001,
		ST_CHECK  = 6'b000010,
		ST_SEND   = 6'b000100,
		ST_WAIT   = 6'b001000,
		ST_SETTLE = 6'b010000,
		ST_DONE   = 6'b100000
	} dci_state_t;
endpackage

// ### hw/dci_init_host.sv
// Boot sequencer that programs a DDR controller's config port.
// Assumes an AXI4-Lite master on aclk and a device port on cfg_clk.
`timescale 1ns/100ps
module dci_init_host #(
	parameter int SETTLE2 = dci_pkg::SETTLE_DDR2_CYC,
	parameter int SETTLE3 = dci_pkg::SETTLE_DDR3_CYC
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [7:0]       awaddr,
	input  wire logic             awvalid,
	output logic                  awready,
	input  wire logic [31:0]      wdata,
	input  wire logic [3:0]       wstrb,
	input  wire logic             wvalid,
	output logic                  wready,
	output logic [1:0]            bresp,
	output logic                  bvalid,
	input  wire logic             bready,
	input  wire logic [7:0]       araddr,
	input  wire logic             arvalid,
	output logic                  arready,
	output logic [31:0]           rdata,
	output logic [1:0]            rresp,
	output logic                  rvalid,
	input  wire logic             rready,
	input  wire logic             cfg_clk,
	output logic                  cfg_valid,
	output dci_pkg::dci_cfg_t     cfg_word,
	input  wire logic             cfg_ready
);
	import dci_pkg::*;

	logic [31:0] ctrl, size, tim_a, tim_b, geom;
	logic        aw_got, w_got, start, busy, done, err;
	logic [7:0]  wa;
	logic [31:0] wd;
	dci_state_t  state;
	logic [3:0]  step;
	logic [CNT_W-1:0] cnt;
	logic        req_tgl, ack_s1, ack_s2;
	dci_cfg_t    req;
	logic        rq_s1, rq_s2, seen, ack_tgl, lr_s1, lr_s2;

	function automatic logic map_ok(input logic [7:0] a);
		return a == REG_CTRL || a == REG_STATUS || a == REG_SIZE ||
			a == REG_TIM_A || a == REG_TIM_B || a == REG_GEOM;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o,
			input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] base_of(input logic [31:0] sz,
			input logic [1:0] n);
		logic [7:0] b;
		b = 8'h00;
		for (int i = 0; i < 4; i++) begin
			if (i < int'(n)) begin
				b = b + sz[i*8 +: 8];
			end
		end
		return b;
	endfunction

	////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			aw_got  <= 1'b0;
			wa      <= 8'h00;
		end else if (awvalid && awready) begin
			awready <= 1'b0;
			aw_got  <= 1'b1;
			wa      <= awaddr;
		end else if (bvalid && bready) begin
			aw_got  <= 1'b0;
		end else begin
			awready <= !aw_got && !bvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready <= 1'b0;
			w_got  <= 1'b0;
			wd     <= 32'h0000_0000;
		end else if (wvalid && wready) begin
			wready <= 1'b0;
			w_got  <= 1'b1;
			wd     <= merge(32'h0000_0000, wdata, wstrb);
		end else if (bvalid && bready) begin
			w_got  <= 1'b0;
		end else begin
			wready <= !w_got && !bvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= 2'h0;
		end else if (aw_got && w_got && !bvalid) begin
			bvalid <= 1'b1;
			bresp  <= map_ok(wa) ? 2'h0 : 2'h2;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Registers take the whole word; unstrobed bytes arrive as zero in wd
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl  <= CTRL_RST;
			size  <= 32'h0000_0000;
			tim_a <= 32'h0000_0000;
			tim_b <= 32'h0000_0000;
			geom  <= 32'h0000_0000;
			start <= 1'b0;
		end else begin
			start <= 1'b0;
			if (aw_got && w_got && !bvalid) begin
				case (wa)
					REG_CTRL: begin
						ctrl  <= wd;
						start <= wd[0] && !busy;
					end
					REG_SIZE:  size  <= wd;
					REG_TIM_A: tim_a <= wd;
					REG_TIM_B: tim_b <= wd;
					REG_GEOM:  geom  <= wd;
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= 2'h0;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= map_ok(araddr) ? 2'h0 : 2'h2;
			case (araddr)
				REG_CTRL:   rdata <= {ctrl[31:1], 1'b0};
				REG_STATUS: rdata <= {25'h0, step, err, done, busy};
				REG_SIZE:   rdata <= size;
				REG_TIM_A:  rdata <= tim_a;
				REG_TIM_B:  rdata <= tim_b;
				REG_GEOM:   rdata <= geom;
				default:    rdata <= 32'h0000_0000;
			endcase
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
		end else begin
			arready <= !rvalid;
		end
	end

	////////////////////////////////////////////////////////////////
	// Config word builder
	logic       ddr3, bchop, bypass;
	logic [4:0] cas, a2p;
	logic [6:0] rfc;
	logic [3:0] a2rw, al, wrec, w2r, single;
	logic [2:0] wl;
	logic [1:0] cs;
	dci_cfg_t   word;

	always_comb begin
		ddr3   = ctrl[1];
		bchop  = ctrl[2];
		bypass = ctrl[3];
		a2rw   = tim_a[3:0];
		al     = tim_a[7:4];
		cas    = tim_a[12:8];
		a2p    = tim_a[20:16];
		rfc    = tim_a[27:21];
		wrec   = tim_b[3:0];
		w2r    = tim_b[7:4];
		if (ddr3 && bchop) begin
			wrec = wrec + BC_EXTRA;
			w2r  = w2r + BC_EXTRA;
		end
		wl = ddr3 ? tim_a[15:13] : 3'(cas - WL_OFFSET);
		cs = step[1:0];
		single = {3'h0, size[7:0] != 0} + {3'h0, size[15:8] != 0} +
			{3'h0, size[23:16] != 0} + {3'h0, size[31:24] != 0};
		word.addr = {4'h0, step};
		word.data = 32'h0000_0000;
		case (step)
			4'h0, 4'h1, 4'h2, 4'h3: begin
				word.addr = DEV_BOUNDS + {6'h0, cs};
				word.data = 32'(base_of(size, cs)) << P_BND_START |
					32'(8'(base_of(size, cs) + size[cs*8 +: 8] - 8'h01));
			end
			4'h4, 4'h5, 4'h6, 4'h7: begin
				word.addr = DEV_SETUP + {6'h0, cs};
				word.data = 32'(size[cs*8 +: 8] != 0) << P_SU_EN |
					32'(geom[7 + cs]) << P_SU_AP |
					32'(ctrl[10:8]) << P_SU_WRT |
					32'(single == 4'h1 ? 3'h0 : ctrl[7:5]) << P_SU_RDT |
					32'(geom[6]) << P_SU_BA |
					32'(geom[2:0]) << P_SU_ROW |
					32'(geom[5:3]) << P_SU_COL;
			end
			4'h8: begin
				word.addr = DEV_TIM3;
				word.data = 32'(rfc[6:4]) | 32'(a2p[4]) << P_T_B |
					32'(cas[4]) << P_T_C;
			end
			4'h9: begin
				word.addr = DEV_TIM0;
				word.data = 32'(ddr3 ? PD_EXIT_DDR3 : tim_b[11:8]) |
					32'(tim_b[15:12]) << P_T_B |
					32'(tim_b[19:16]) << P_T_C;
			end
			4'ha: begin
				word.addr = DEV_TIM1;
				word.data = 32'(rfc[3:0]) | 32'(a2p[3:0]) << P_HI |
					32'(a2rw) << P_T_B | 32'(cas[3:0]) << (P_T_B + P_HI) |
					32'(wrec) << P_T_C | 32'(w2r) << P_T_D;
			end
			4'hb: begin
				word.addr = DEV_TIM2;
				word.data = 32'(al) | 32'(wl) << P_T_B;
			end
			4'hc: begin
				word.addr = DEV_CLKADJ;
				word.data = 32'(geom[13:11]) << P_T_D;
			end
			default: begin
				word.addr = DEV_MEMCFG;
				word.data = 32'(1'b1) << P_CFG_EN |
					32'(ddr3) << P_CFG_DDR3 | 32'(bypass) << P_CFG_BI;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state   <= ST_IDLE;
			step    <= 4'h0;
			cnt     <= '0;
			busy    <= 1'b0;
			done    <= 1'b0;
			err     <= 1'b0;
			req_tgl <= 1'b0;
			req     <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start) begin
						busy  <= 1'b1;
						done  <= 1'b0;
						err   <= 1'b0;
						step  <= 4'h0;
						state <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					if (al >= a2rw) begin
						err   <= 1'b1;
						state <= ST_DONE;
					end else begin
						state <= ST_SEND;
					end
				end
				ST_SEND: begin
					req     <= word;
					req_tgl <= !req_tgl;
					state   <= ST_WAIT;
				end
				ST_WAIT: begin
					if (ack_s2 == req_tgl) begin
						if (step == STEP_EN) begin
							done  <= 1'b1;
							state <= ST_DONE;
						end else if (step == STEP_CLK) begin
							cnt   <= ddr3 ? CNT_W'(SETTLE3) : CNT_W'(SETTLE2);
							state <= ST_SETTLE;
						end else begin
							step  <= step + 4'h1;
							state <= ST_SEND;
						end
					end
				end
				ST_SETTLE: begin
					if (cnt == '0) begin
						step  <= STEP_EN;
						state <= ST_SEND;
					end else begin
						cnt <= cnt - CNT_W'(1);
					end
				end
				ST_DONE: begin
					busy  <= 1'b0;
					state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end else begin
			ack_s1 <= ack_tgl;
			ack_s2 <= ack_s1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Link side on cfg_clk
	always_ff @(posedge cfg_clk) begin
		lr_s1 <= aresetn;
		lr_s2 <= lr_s1;
	end

	always_ff @(posedge cfg_clk) begin
		if (!lr_s2) begin
			rq_s1 <= 1'b0;
			rq_s2 <= 1'b0;
		end else begin
			rq_s1 <= req_tgl;
			rq_s2 <= rq_s1;
		end
	end

	// req is held steady from the toggle until the ack returns
	always_ff @(posedge cfg_clk) begin
		if (!lr_s2) begin
			cfg_valid <= 1'b0;
			cfg_word  <= '0;
			seen      <= 1'b0;
			ack_tgl   <= 1'b0;
		end else if (cfg_valid && cfg_ready) begin
			cfg_valid <= 1'b0;
			ack_tgl   <= seen;
		end else if (!cfg_valid && rq_s2 != seen) begin
			cfg_valid <= 1'b1;
			cfg_word  <= req;
			seen      <= rq_s2;
		end
	end
endmodule

// ### dv/dci_init_host_chk.sv
// Assertions on the init sequencer's AXI answers and its link words.
// Bound to dci_init_host; sees only that module's ports.
`timescale 1ns/100ps
module dci_init_host_chk
	import dci_pkg::*;
(
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              bvalid,
	input wire logic              bready,
	input wire logic [1:0]        bresp,
	input wire logic              arvalid,
	input wire logic              arready,
	input wire logic [7:0]        araddr,
	input wire logic              rvalid,
	input wire logic              rready,
	input wire logic [31:0]       rdata,
	input wire logic [1:0]        rresp,
	input wire logic              cfg_clk,
	input wire logic              cfg_valid,
	input wire dci_pkg::dci_cfg_t cfg_word,
	input wire logic              cfg_ready
);
	logic [7:0] exp_addr;

	// Index of the next word the link must carry
	always_ff @(posedge cfg_clk) begin
		if (!aresetn)
			exp_addr <= 8'h00;
		else if (cfg_valid && cfg_ready)
			exp_addr <= (cfg_word.addr == DEV_MEMCFG) ? 8'h00
				: cfg_word.addr + 8'h01;
	end

	AST_LINK_HOLD: assert property (@(posedge cfg_clk)
		disable iff (!aresetn)
		cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_word))
		else $error("link word changed before it was taken");
	AST_LINK_DROP: assert property (@(posedge cfg_clk)
		disable iff (!aresetn) cfg_valid && cfg_ready |=> !cfg_valid)
		else $error("link valid held after take");
	AST_LINK_ORDER: assert property (@(posedge cfg_clk)
		disable iff (!aresetn) cfg_valid |-> cfg_word.addr == exp_addr)
		else $error("link word out of order");
	AST_EN_LAST: assert property (@(posedge cfg_clk)
		disable iff (!aresetn)
		cfg_valid && cfg_word.addr == DEV_MEMCFG |-> cfg_word.data[P_CFG_EN])
		else $error("last word lacks the enable bit");
	AST_B_HOLD: assert property (@(posedge aclk)
		disable iff (!aresetn) bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response not held");
	AST_R_HOLD: assert property (@(posedge aclk)
		disable iff (!aresetn)
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read data not held");
	AST_R_AFTER: assert property (@(posedge aclk)
		disable iff (!aresetn) arvalid && arready |=> rvalid)
		else $error("read answer late");
	AST_UNMAPPED: assert property (@(posedge aclk)
		disable iff (!aresetn) arvalid && arready && araddr > REG_GEOM
		|=> rresp == 2'b10 && rdata == 32'h0)
		else $error("unmapped read not refused");
endmodule

bind dci_init_host dci_init_host_chk u_chk (
	.aclk(aclk), .aresetn(aresetn), .bvalid(bvalid), .bready(bready),
	.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
	.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
	.cfg_clk(cfg_clk), .cfg_valid(cfg_valid), .cfg_word(cfg_word),
	.cfg_ready(cfg_ready)
);

// ### dv/dci_dev_model.sv
// Behavioural DDR controller config port: stores words, takes enable.
// Assumes words arrive on cfg_clk; slow makes it stall every other edge.
`timescale 1ns/100ps
module dci_dev_model
	import dci_pkg::*;
(
	input wire logic              cfg_clk,
	input wire logic              rst_n,
	input wire logic              slow,
	input wire logic              cfg_valid,
	input wire dci_pkg::dci_cfg_t cfg_word,
	output logic                  cfg_ready
);
	logic [31:0] mem [0:13];
	logic        mem_en;
	logic        auto_init;
	int          n_words;
	realtime     t_clk;
	realtime     t_en;

	always_ff @(posedge cfg_clk) begin
		if (!rst_n)
			cfg_ready <= 1'b0;
		else
			cfg_ready <= slow ? ~cfg_ready : 1'b1;
	end

	always_ff @(posedge cfg_clk) begin
		if (!rst_n) begin
			n_words <= 0;
			mem_en <= 1'b0;
		end else if (cfg_valid && cfg_ready) begin
			n_words <= n_words + 1;
			if (cfg_word.addr <= DEV_MEMCFG)
				mem[cfg_word.addr[3:0]] <= cfg_word.data;
			if (cfg_word.addr == DEV_CLKADJ)
				t_clk <= $realtime;
			if (cfg_word.addr == DEV_MEMCFG) begin
				mem_en <= cfg_word.data[P_CFG_EN];
				auto_init <= !cfg_word.data[P_CFG_BI];
				t_en <= $realtime;
			end
		end
	end

	// Chip select whose bounds hold a block address, -1 when none
	function automatic int cs_of(input logic [7:0] a);
		cs_of = -1;
		for (int n = 3; n >= 0; n--)
			if (mem_en && mem[4+n][P_SU_EN] && a >= mem[n][23:16]
				&& a <= mem[n][7:0])
				cs_of = n;
	endfunction
endmodule

// ### dv/ddr_ctrl_init_config_tb_top.sv
// Testbench for the DDR init sequencer: AXI tasks and a config port model.
// Assumes dci_pkg, the design, the checker and the model are compiled.
`timescale 1ns/100ps
module ddr_ctrl_init_config_tb_top;
	import dci_pkg::*;
	logic        aclk = 1'b0;
	logic        cfg_clk = 1'b0;
	logic        aresetn = 1'b0;
	logic        slow = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        cfg_valid, cfg_ready;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	dci_cfg_t    cfg_word;
	int          n_mismatch = 0;
	int          checked = 0;

	always #2.5 aclk = ~aclk;
	always #3 cfg_clk = ~cfg_clk;

	dci_init_host #(.SETTLE2(20), .SETTLE3(20)) dut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready),
		.cfg_clk(cfg_clk), .cfg_valid(cfg_valid), .cfg_word(cfg_word),
		.cfg_ready(cfg_ready)
	);
	dci_dev_model dev (
		.cfg_clk(cfg_clk), .rst_n(aresetn), .slow(slow),
		.cfg_valid(cfg_valid), .cfg_word(cfg_word), .cfg_ready(cfg_ready)
	);

	////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tmo(input string nm);
		n_mismatch++;
		$display("[ERR] %s expected answer seen timeout", nm);
		print_verdict();
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int i;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (i == 40) tmo("bvalid");
		bready <= 1'b0;
		r = bresp;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int i;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (i == 40) tmo("rvalid");
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask

	// Start a run and poll status until it ends; returns status
	task automatic run(input logic [31:0] ctrl, input bit err,
		output logic [31:0] s);
		logic [1:0] r;
		int         n0, i;
		n0 = dev.n_words;
		axi_wr(REG_CTRL, ctrl, r);
		for (i = 0; i < 400; i++) begin
			axi_rd(REG_STATUS, s, r);
			if (!s[0] && (err ? s[2] : dev.n_words == n0 + 14)) break;
		end
		if (i == 400) tmo("status");
		chk("words sent", err ? 0 : 14, dev.n_words - n0);
		chk("status", err ? 32'h4 : 32'h2, {29'h0, s[2:0]});
	endtask

	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(REG_CTRL, d, r);
		chk("ctrl reset", CTRL_RST, d);
		axi_rd(8'h40, d, r);
		chk("unmapped rresp", 32'h2, {30'h0, r});
		axi_wr(8'h40, 32'h1, r);
		chk("unmapped bresp", 32'h2, {30'h0, r});
		axi_wr(REG_SIZE, 32'h0408_0404, r);
		axi_rd(REG_SIZE, d, r);
		chk("size", 32'h0408_0404, d);
		$display("test regs done");
	endtask

	task automatic t_abort();
		logic [31:0] s;
		logic [1:0]  r;
		axi_wr(REG_TIM_A, 32'h0000_0533, r);
		run(32'h0000_0101, 1'b1, s);
		chk("no select before enable", 32'hffff_ffff, dev.cs_of(8'h00));
		$display("test abort done");
	endtask

	task automatic t_ddr2();
		logic [31:0] s;
		logic [1:0]  r;
		axi_wr(REG_SIZE, 32'h0000_0010, r);
		axi_wr(REG_TIM_A, 32'h0018_0525, r);
		axi_wr(REG_GEOM, 32'h0000_10d5, r);
		run(32'h0000_0161, 1'b0, s);
		chk("cfg bits", 32'h8000_0000, dev.mem[13] & 32'h8100_0001);
		chk("auto init", 32'h1, 32'(dev.auto_init));
		chk("cs0 wr term", 32'h1, 32'(dev.mem[4][18:16]));
		chk("cs0 rd term", 32'h0, 32'(dev.mem[4][22:20]));
		chk("cs0 ap en", 32'h3, 32'(dev.mem[4][31:30]));
		chk("cs1 en", 32'h0, 32'(dev.mem[5][30]));
		chk("ddr2 wl", 32'h4, 32'(dev.mem[11][10:8]));
		chk("act to pre", 32'h18, {27'h0, dev.mem[8][8], dev.mem[10][7:4]});
		chk("settle", 32'h1, 32'(dev.t_en - dev.t_clk >= 100.0));
		$display("test ddr2 done");
	endtask

	task automatic t_ddr3();
		logic [31:0] s;
		logic [1:0]  r;
		slow <= 1'b1;
		axi_wr(REG_SIZE, 32'h0408_0404, r);
		axi_wr(REG_TIM_A, 32'h0000_6525, r);
		axi_wr(REG_TIM_B, 32'h0000_0546, r);
		axi_wr(REG_GEOM, 32'h0000_12d5, r);
		run(32'h0000_014f, 1'b0, s);
		chk("cfg bits", 32'h8100_0001, dev.mem[13] & 32'h8100_0001);
		chk("auto init", 32'h0, 32'(dev.auto_init));
		chk("cs0 rd term", 32'h2, 32'(dev.mem[4][22:20]));
		chk("cs1 ap", 32'h0, 32'(dev.mem[5][31]));
		chk("cs2 ap", 32'h1, 32'(dev.mem[6][31]));
		chk("termination_powerdown_exit", 32'h1, 32'(dev.mem[9][3:0]));
		chk("wr recovery", 32'h8, 32'(dev.mem[10][19:16]));
		chk("wr to rd", 32'h6, 32'(dev.mem[10][27:24]));
		chk("ddr3 wl", 32'h3, 32'(dev.mem[11][10:8]));
		chk("contiguous", 32'(dev.mem[0][7:0] + 8'h01),
			32'(dev.mem[1][23:16]));
		chk("cs2 select", 32'h2, dev.cs_of(dev.mem[2][23:16]));
		chk("settle", 32'h1, 32'(dev.t_en - dev.t_clk >= 100.0));
		$display("test ddr3 done");
	endtask

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_abort();
		t_ddr2();
		t_ddr3();
		print_verdict();
	end
endmodule
